// >>> pkg/flash_bank_pkg.sv
package flash_bank_pkg;

   // Command bytes seen on the data lane
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_IDENT_A = 8'h80;
   localparam logic [7:0] CMD_IDENT_B = 8'h90;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_RESET = 8'hFF;

   // Content of an erased byte
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Idle value driven on the data lane
   localparam logic [7:0] IDLE_BYTE = 8'h00;

   // Identification read addresses
   localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
   localparam logic [15:0] ID_PART_ADDR = 16'h0001;

   // Register bus geometry
   localparam int AXI_ADDR_WIDTH = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IDENT = 8'h08;

   // Control register fields and reset value
   localparam int CTRL_PROTECT_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_ERASING_BIT = 3;
   localparam int STAT_VPP_BIT = 4;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operating modes of the command state machine
   typedef enum logic [2:0] {
      MODE_READ = 3'b000,
      MODE_IDENT = 3'b001,
      MODE_ERASE_SETUP = 3'b010,
      MODE_ERASING = 3'b011,
      MODE_ERASE_VERIFY = 3'b100,
      MODE_PROG_SETUP = 3'b101,
      MODE_PROG_VERIFY = 3'b110,
      MODE_RESET_ARMED = 3'b111
   } mode_type;

endpackage

// >>> src/flash_reg_slave.sv
`timescale 1ns/100ps
module flash_reg_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] status_word,
   input wire logic [31:0] ident_word,
   output logic write_protect
);

   logic aw_held_q, aw_held_d; // Address taken, waiting for data
   logic w_held_q, w_held_d; // Data taken, waiting for address
   logic [7:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d;
   logic bvalid_q, bvalid_d;
   logic arready_q, arready_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] ctrl_q, ctrl_d; // Software control word
   logic awready_q, awready_d; // Registered so the pin leaves a flop
   logic wready_q, wready_d;

   // Write and read channel next values
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      bvalid_d = bvalid_q;
      ctrl_d = ctrl_q;
      arready_d = arready_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      rvalid_d = rvalid_q;
      // Address and data may come in either order
      if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
         aw_held_d = 1'b1;
         waddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
         w_held_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (aw_held_q && w_held_q && !bvalid_q) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         if (waddr_q == flash_bank_pkg::REG_CTRL) begin
            bresp_d = flash_bank_pkg::RESP_OKAY;
            if (wstrb_q[0]) begin
               ctrl_d[7:0] = wdata_q[7:0];
            end
         end else if (waddr_q == flash_bank_pkg::REG_STATUS ||
                      waddr_q == flash_bank_pkg::REG_IDENT) begin
            // Read-only words ignore the data
            bresp_d = flash_bank_pkg::RESP_OKAY;
         end else begin
            bresp_d = flash_bank_pkg::RESP_SLVERR;
         end
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // One read at a time; arready drops while the answer waits
      if (rvalid_q) begin
         if (s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
         end
      end else if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         arready_d = 1'b0;
         rresp_d = flash_bank_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            flash_bank_pkg::REG_CTRL: rdata_d = ctrl_q;
            flash_bank_pkg::REG_STATUS: rdata_d = status_word;
            flash_bank_pkg::REG_IDENT: rdata_d = ident_word;
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = flash_bank_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Ready follows the next held state, one flop deep
      awready_d = !aw_held_d && !bvalid_d;
      wready_d = !w_held_d && !bvalid_d;
   end

   // Register stage with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= flash_bank_pkg::RESP_OKAY;
         bvalid_q <= 1'b0;
         ctrl_q <= flash_bank_pkg::CTRL_RESET;
         arready_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         rresp_q <= flash_bank_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
         bvalid_q <= bvalid_d;
         ctrl_q <= ctrl_d;
         arready_q <= arready_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         rvalid_q <= rvalid_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
      end
   end

   // Ready flags are flops, so held halves stall the channel
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign write_protect = ctrl_q[flash_bank_pkg::CTRL_PROTECT_BIT];

endmodule

// >>> src/flash_byte_device.sv
// Operation
// - Codes 80H or 90H enter identification mode
// - Identification read at address 0 gives maker
// - Identification read at address 1 gives part
// - Only another command write, a disabled command register or reset leaves identification
// - Verify command latches address for next read
// - Erase verify command ends the erase pulse
// - Low programming supply makes device read-only
// - Erase and program need setup then command
// - Write only when select, write low, output high
`timescale 1ns/100ps
module flash_byte_device #(
   parameter int ADDR_WIDTH = 8,
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_out_en,
   input wire logic vpp_high
);

   // Array depth follows the address width
   localparam int DEPTH = 1 << ADDR_WIDTH;

   // Elaboration check on the address width
   generate
      if (ADDR_WIDTH < 1 || ADDR_WIDTH > 16) begin : g_bad_width
         $error("ADDR_WIDTH must lie between 1 and 16");
      end
   endgenerate

   logic [7:0] mem [0:DEPTH-1]; // Nonvolatile array, never reset
   flash_bank_pkg::mode_type mode_q, mode_d; // Command state
   logic [ADDR_WIDTH-1:0] latch_q, latch_d; // Verify address
   logic [ADDR_WIDTH-1:0] erase_ptr_q, erase_ptr_d; // Erase walker
   logic wr_seen_q, wr_seen_d; // Write strobe already taken
   logic [7:0] data_out_q, data_out_d;
   logic data_oe_q, data_oe_d;
   logic write_protect; // Software lock from the control register
   logic cmd_enable; // Command register usable
   logic wr_cond; // Pins in the write combination
   logic rd_cond; // Pins in the read combination
   logic write_take; // One pulse per accepted write
   logic mem_we;
   logic [ADDR_WIDTH-1:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] read_value;
   logic [31:0] status_word;
   logic [31:0] ident_word;

   // Register bus slave holding the control word
   flash_reg_slave u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .status_word(status_word),
      .ident_word(ident_word),
      .write_protect(write_protect)
   );

   // Status view of the live state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[flash_bank_pkg::STAT_MODE_LSB +: 3] = mode_q;
      status_word[flash_bank_pkg::STAT_ERASING_BIT] =
         (mode_q == flash_bank_pkg::MODE_ERASING);
      status_word[flash_bank_pkg::STAT_VPP_BIT] = vpp_high;
      ident_word = {16'h0000, PART_CODE, MAKER_CODE};
   end

   // Pin decode; the write is taken once per strobe
   always_comb begin
      cmd_enable = vpp_high && !write_protect;
      wr_cond = !chip_select_n && !write_enable_n && output_enable_n;
      rd_cond = !chip_select_n && !output_enable_n && write_enable_n;
      write_take = wr_cond && !wr_seen_q && cmd_enable;
      wr_seen_d = wr_cond;
   end

   // Map a fresh command byte onto a mode
   function automatic flash_bank_pkg::mode_type decode(input logic [7:0] cmd);
      flash_bank_pkg::mode_type m;
      unique case (cmd)
         flash_bank_pkg::CMD_IDENT_A: m = flash_bank_pkg::MODE_IDENT;
         flash_bank_pkg::CMD_IDENT_B: m = flash_bank_pkg::MODE_IDENT;
         flash_bank_pkg::CMD_ERASE: m = flash_bank_pkg::MODE_ERASE_SETUP;
         flash_bank_pkg::CMD_PROGRAM: m = flash_bank_pkg::MODE_PROG_SETUP;
         flash_bank_pkg::CMD_ERASE_VERIFY: m = flash_bank_pkg::MODE_ERASE_VERIFY;
         flash_bank_pkg::CMD_PROGRAM_VERIFY: m = flash_bank_pkg::MODE_PROG_VERIFY;
         flash_bank_pkg::CMD_RESET: m = flash_bank_pkg::MODE_RESET_ARMED;
         // Read and any illegal byte fall back to read mode
         default: m = flash_bank_pkg::MODE_READ;
      endcase
      return m;
   endfunction

   // Command state machine and array write port
   always_comb begin
      mode_d = mode_q;
      latch_d = latch_q;
      erase_ptr_d = erase_ptr_q;
      mem_we = 1'b0;
      mem_addr = address;
      mem_wdata = data_in;
      // Erase walks the array one byte per cycle until stopped
      // A disabled command register must not alter the array
      if (mode_q == flash_bank_pkg::MODE_ERASING && cmd_enable) begin
         mem_we = 1'b1;
         mem_addr = erase_ptr_q;
         mem_wdata = flash_bank_pkg::ERASED_BYTE;
         erase_ptr_d = erase_ptr_q + 1'b1;
      end
      if (!cmd_enable) begin
         // Supply low or locked: read-only, pending setups dropped
         mode_d = flash_bank_pkg::MODE_READ;
      end else if (write_take) begin
         unique case (mode_q)
            flash_bank_pkg::MODE_ERASE_SETUP: begin
               // Setup alone leaves contents alone
               erase_ptr_d = '0;
               mode_d = (data_in == flash_bank_pkg::CMD_ERASE) ?
                  flash_bank_pkg::MODE_ERASING : flash_bank_pkg::MODE_READ;
            end
            flash_bank_pkg::MODE_PROG_SETUP: begin
               // Programming only clears bits
               mem_we = 1'b1;
               mem_wdata = mem[address] & data_in;
               mode_d = flash_bank_pkg::MODE_READ;
            end
            flash_bank_pkg::MODE_RESET_ARMED: begin
               // Second reset byte in a row confirms read mode
               mode_d = (data_in == flash_bank_pkg::CMD_RESET) ?
                  flash_bank_pkg::MODE_READ : decode(data_in);
            end
            default: begin
               // Any valid write leaves erase; any but 80H or 90H leaves identification
               mode_d = decode(data_in);
            end
         endcase
         // Verify commands capture the address for the next read
         if ((data_in == flash_bank_pkg::CMD_ERASE_VERIFY ||
              data_in == flash_bank_pkg::CMD_PROGRAM_VERIFY) &&
             mode_q != flash_bank_pkg::MODE_ERASE_SETUP &&
             mode_q != flash_bank_pkg::MODE_PROG_SETUP) begin
            latch_d = address;
         end
      end
   end

   // Read data source by mode
   always_comb begin
      unique case (mode_q)
         flash_bank_pkg::MODE_IDENT: begin
            if (address == ADDR_WIDTH'(flash_bank_pkg::ID_MAKER_ADDR)) begin
               read_value = MAKER_CODE;
            end else if (address == ADDR_WIDTH'(flash_bank_pkg::ID_PART_ADDR)) begin
               read_value = PART_CODE;
            end else begin
               read_value = flash_bank_pkg::IDLE_BYTE;
            end
         end
         flash_bank_pkg::MODE_ERASE_VERIFY,
         flash_bank_pkg::MODE_PROG_VERIFY: read_value = mem[latch_q];
         default: read_value = mem[address];
      endcase
      data_out_d = rd_cond ? read_value : flash_bank_pkg::IDLE_BYTE;
      data_oe_d = rd_cond;
   end

   // Array write; contents survive reset on purpose
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= flash_bank_pkg::MODE_READ;
         latch_q <= '0;
         erase_ptr_q <= '0;
         wr_seen_q <= 1'b0;
         data_out_q <= flash_bank_pkg::IDLE_BYTE;
         data_oe_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         latch_q <= latch_d;
         erase_ptr_q <= erase_ptr_d;
         wr_seen_q <= wr_seen_d;
         data_out_q <= data_out_d;
         data_oe_q <= data_oe_d;
      end
   end

   assign data_out = data_out_q;
   assign data_out_en = data_oe_q;

   // Accepted command writes of interest
   sequence s_ident_write;
      write_take && (data_in == flash_bank_pkg::CMD_IDENT_A ||
                     data_in == flash_bank_pkg::CMD_IDENT_B) &&
      mode_q != flash_bank_pkg::MODE_ERASE_SETUP &&
      mode_q != flash_bank_pkg::MODE_PROG_SETUP;
   endsequence

   sequence s_verify_write;
      write_take && data_in == flash_bank_pkg::CMD_ERASE_VERIFY &&
      mode_q != flash_bank_pkg::MODE_ERASE_SETUP &&
      mode_q != flash_bank_pkg::MODE_PROG_SETUP;
   endsequence

   sequence s_verify_read;
      rd_cond && !write_take && cmd_enable;
   endsequence

   property p_ident_entry;
      @(posedge aclk) disable iff (!aresetn)
      s_ident_write |=> mode_q == flash_bank_pkg::MODE_IDENT;
   endproperty
   a_ident_entry: assert property (p_ident_entry) else $error("ident code not entered");

   property p_ident_maker;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_IDENT && rd_cond && cmd_enable &&
       address == ADDR_WIDTH'(flash_bank_pkg::ID_MAKER_ADDR))
      |=> data_out_en && data_out == MAKER_CODE;
   endproperty
   a_ident_maker: assert property (p_ident_maker) else $error("maker code wrong");

   property p_ident_part;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_IDENT && rd_cond && cmd_enable &&
       address == ADDR_WIDTH'(flash_bank_pkg::ID_PART_ADDR))
      |=> data_out_en && data_out == PART_CODE;
   endproperty
   a_ident_part: assert property (p_ident_part) else $error("part code wrong");

   property p_ident_holds;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_IDENT && !write_take && cmd_enable)
      |=> mode_q == flash_bank_pkg::MODE_IDENT;
   endproperty
   a_ident_holds: assert property (p_ident_holds) else $error("ident left without write");

   property p_verify_latch;
      @(posedge aclk) disable iff (!aresetn)
      s_verify_write |=> latch_q == $past(address);
   endproperty
   a_verify_latch: assert property (p_verify_latch) else $error("verify read not latched");

   property p_verify_read;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_ERASE_VERIFY) ##0 s_verify_read
      |=> data_out_en && data_out == mem[$past(latch_q)];
   endproperty
   a_verify_read: assert property (p_verify_read) else $error("verify read not from latch");

   property p_erase_stops;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_ERASING) ##0 s_verify_write
      |=> mode_q == flash_bank_pkg::MODE_ERASE_VERIFY
      ##1 mode_q != flash_bank_pkg::MODE_ERASING;
   endproperty
   a_erase_stops: assert property (p_erase_stops) else $error("erase not ended");

   property p_supply_low;
      @(posedge aclk) disable iff (!aresetn)
      !vpp_high |=> mode_q == flash_bank_pkg::MODE_READ && $stable(latch_q);
   endproperty
   a_supply_low: assert property (p_supply_low) else $error("command taken at low supply");

   property p_setup_only;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_ERASE_SETUP && write_take &&
       data_in != flash_bank_pkg::CMD_ERASE)
      |=> mode_q == flash_bank_pkg::MODE_READ ##1 mode_q != flash_bank_pkg::MODE_ERASING;
   endproperty
   a_setup_only: assert property (p_setup_only) else $error("setup alone started erase");

   property p_write_gate;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q == flash_bank_pkg::MODE_READ && !output_enable_n && cmd_enable)
      |=> mode_q == flash_bank_pkg::MODE_READ;
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("write taken with output on");

endmodule

// >>> testbench/flash_pin_driver.sv
`timescale 1ns/100ps
// Controller side of the flash pins
module flash_pin_driver (
   input wire logic aclk,
   input wire logic [7:0] data_out,
   output logic chip_select_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic [7:0] address,
   output logic [7:0] data_in
);
   // All strobes idle at time zero
   initial begin
      chip_select_n = 1'b1;
      output_enable_n = 1'b1;
      write_enable_n = 1'b1;
      address = 8'h00;
      data_in = 8'hA5;
   end
   // One write strobe; a low oe_n makes a deliberately bad write
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic oe_n = 1'b1);
      chip_select_n <= 1'b0;
      write_enable_n <= 1'b0;
      output_enable_n <= oe_n;
      address <= a;
      data_in <= d;
      @(posedge aclk);
      chip_select_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      data_in <= ~d; // Released lane never keeps the old byte
      @(posedge aclk);
   endtask
   // Read strobe; data is registered, so it is taken two edges on
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      chip_select_n <= 1'b0;
      output_enable_n <= 1'b0;
      address <= a;
      @(posedge aclk);
      @(posedge aclk);
      d = data_out;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      @(posedge aclk);
   endtask
endmodule

// >>> testbench/dual_flash_parallel_erase_program_bench.sv
`timescale 1ns/100ps
module dual_flash_parallel_erase_program_bench;
   logic aclk, aresetn, vpp_high, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, cs_n, oe_n, we_n, data_out_en;
   logic [7:0] awaddr, araddr, addr, din, dout, b;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r;
   int pulse_counter; // Erase pulses spent
   logic [15:0] erase_command_word, erase_verify_command_word; // High lane in 15:8
   logic [7:0] low_lane_address, flash_read_value; // Next address to verify, byte seen
   int miscompares = 0;
   int cmp_count = 0;
   flash_byte_device u_flash_byte_device (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .chip_select_n(cs_n), .output_enable_n(oe_n),
      .write_enable_n(we_n), .address(addr), .data_in(din), .data_out(dout),
      .data_out_en(data_out_en), .vpp_high(vpp_high));
   flash_pin_driver u_flash_pin_driver (.aclk(aclk), .data_out(dout), .chip_select_n(cs_n),
      .output_enable_n(oe_n), .write_enable_n(we_n), .address(addr), .data_in(din));
   // 250 MHz clock
   always #2 aclk = ~aclk;
   // Comparison with count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus write; both halves offered together, each dropped when taken
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   // Bus read
   task automatic br(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready && arvalid) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Status low five bits: vpp, erasing, mode
   task automatic st(input logic [4:0] e);
      br(flash_bank_pkg::REG_STATUS);
      chk("status", {27'h0, e}, {27'h0, v[4:0]});
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, far beyond the sequence length
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      summarize();
   end
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      vpp_high = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      br(flash_bank_pkg::REG_CTRL);
      chk("ctrl", 32'h0, v);
      br(8'h0C);
      chk("unmapped data", 32'h0, v);
      chk("unmapped resp", 32'h2, {30'h0, r});
      br(flash_bank_pkg::REG_IDENT);
      chk("ident", 32'h0000_C35A, v);
      // Both identification codes, then leave by a command write
      for (int i = 0; i < 2; i++) begin
         u_flash_pin_driver.wr(8'h00, i ? 8'h90 : 8'h80);
         u_flash_pin_driver.rd(8'h00, b);
         chk("maker", 32'h5A, {24'h0, b});
         u_flash_pin_driver.rd(8'h01, b);
         chk("part", 32'hC3, {24'h0, b});
         st(5'h11);
         u_flash_pin_driver.wr(8'h00, 8'h00);
         st(5'h10);
      end
      u_flash_pin_driver.wr(8'h00, 8'h80, 1'b0);
      st(5'h10);
      vpp_high <= 1'b0;
      u_flash_pin_driver.wr(8'h00, 8'h90);
      st(5'h00);
      vpp_high <= 1'b1;
      // Whole array to zero first, so no byte starts erased
      for (int a = 0; a < 256; a++) begin
         u_flash_pin_driver.wr(a[7:0], 8'h40);
         u_flash_pin_driver.wr(a[7:0], 8'h00);
      end
      u_flash_pin_driver.wr(8'h00, 8'h20);
      st(5'h12);
      // Low lane erase loop; the first pulse is too short on purpose
      erase_command_word = 16'h2020;
      erase_verify_command_word = 16'hA0A0;
      low_lane_address = 8'h00;
      pulse_counter = 0;
      while (erase_command_word != 16'h0000 && pulse_counter < 4) begin
         pulse_counter++;
         if (pulse_counter > 1) u_flash_pin_driver.wr(8'h00, erase_command_word[7:0]);
         u_flash_pin_driver.wr(8'h00, erase_command_word[7:0]);
         repeat (160 * pulse_counter) @(posedge aclk);
         st(5'h1B);
         flash_read_value = 8'hFF;
         while (flash_read_value === 8'hFF && erase_command_word[7:0] != 8'h00) begin
            u_flash_pin_driver.wr(low_lane_address, erase_verify_command_word[7:0]);
            u_flash_pin_driver.rd(low_lane_address, flash_read_value);
            if (flash_read_value === 8'hFF) begin
               if (low_lane_address == 8'hFF) erase_command_word[7:0] = 8'h00;
               low_lane_address++;
            end
         end
         // Stand-in high lane verifies on its first pulse and is masked
         erase_command_word[15:8] = 8'h00;
         erase_verify_command_word[15:8] = 8'h00;
      end
      chk("erase word", 32'h0, {16'h0, erase_command_word});
      chk("pulses", 32'h2, pulse_counter);
      u_flash_pin_driver.wr(8'h00, 8'h00);
      st(5'h10);
      u_flash_pin_driver.wr(8'h05, 8'hA0);
      st(5'h14);
      u_flash_pin_driver.rd(8'h05, b);
      chk("erased", 32'hFF, {24'h0, b});
      u_flash_pin_driver.wr(8'h07, 8'h40);
      u_flash_pin_driver.wr(8'h07, 8'h3C);
      u_flash_pin_driver.wr(8'h07, 8'hC0);
      u_flash_pin_driver.rd(8'h00, b);
      chk("programmed", 32'h3C, {24'h0, b});
      // Masked lane sees null data, which leaves the byte as it was
      u_flash_pin_driver.wr(8'h07, 8'h40);
      u_flash_pin_driver.wr(8'h07, 8'hFF);
      u_flash_pin_driver.rd(8'h07, b);
      chk("null data", 32'h3C, {24'h0, b});
      // Erase set-up alone leaves the array alone
      u_flash_pin_driver.wr(8'h00, 8'h20);
      u_flash_pin_driver.wr(8'h00, 8'h00);
      u_flash_pin_driver.rd(8'h07, b);
      chk("setup only", 32'h3C, {24'h0, b});
      u_flash_pin_driver.wr(8'h00, 8'hFF);
      st(5'h17);
      u_flash_pin_driver.wr(8'h00, 8'hFF);
      st(5'h10);
      // Write protect through the register bus
      bw(flash_bank_pkg::REG_CTRL, 32'h1);
      br(flash_bank_pkg::REG_CTRL);
      chk("protect", 32'h1, v);
      u_flash_pin_driver.wr(8'h00, 8'h90);
      st(5'h10);
      bw(8'h0C, 32'h0);
      chk("bad write", 32'h2, {30'h0, r});
      summarize();
   end
endmodule
